// ===== core/aps_sequencer.sv
// Summary of operation
// RULE1: software writes command register last
// RULE2: command write sets busy, sends command frame
// RULE3: device answers with setup frame, word count
// RULE4: setup frame loads beginning status
// RULE5: software writes packet after busy clear
// RULE6: data writes fill fifo, link drains it
// RULE7: throttle link so fifo never underflows
// RULE8: count reached loads final status, closes frame
// RULE9: device sends second setup for write data
// RULE10: write setup sets request, optional interrupt
// RULE11: software reads byte count, writes words
// RULE12: device ends with register frame
// RULE13: register frame copied into shadow registers
// RULE14: software programs dma before command
// RULE15: device sends read data as frame
// RULE16: data frame routed to programmed dma
// RULE17: ending frame clears busy, interrupt if flagged
// RULE18: run flag arms dma, stays paused
// RULE19: activate frame starts armed dma
// RULE20: dma sends exactly the programmed count
// RULE21: busy at bit 7, request bit 3
`timescale 1ns/10ps
`default_nettype none
module aps_sequencer
  import aps_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic host_irq,
  output logic tx_cmd_valid,
  input wire logic tx_cmd_ready,
  output logic [7:0] tx_cmd_command,
  output logic [7:0] tx_cmd_features,
  output logic [7:0] tx_cmd_count,
  output logic [7:0] tx_cmd_device,
  output logic [23:0] tx_cmd_lba,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [15:0] tx_data,
  output logic tx_last,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire aps_frame_t rx_type,
  input wire logic [7:0] rx_status,
  input wire logic [7:0] rx_end_status,
  input wire logic [7:0] rx_error,
  input wire logic [7:0] rx_count_reg,
  input wire logic [23:0] rx_lba,
  input wire logic [15:0] rx_words,
  input wire logic rx_to_host,
  input wire logic rx_irq,
  input wire logic [15:0] rx_data,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [31:0] mem_wr_addr,
  output logic [15:0] mem_wr_data,
  output logic mem_rd_valid,
  input wire logic mem_rd_ready,
  output logic [31:0] mem_rd_addr,
  input wire logic [15:0] mem_rd_data
);
  aps_regs_t r; // all state
  aps_regs_t next_r; // next state
  logic setup_ph; // apb setup cycle
  logic access; // apb access cycle
  logic data_wr; // data write that may push
  logic wr_done; // write completes this edge
  logic rd_done; // read completes this edge
  logic hit; // mapped address
  logic [31:0] rd_mux; // read value
  logic push; // fifo push
  logic [15:0] push_data; // fifo input word
  logic pop; // fifo pop to link
  logic fifo_in_ready; // fifo has room
  logic fifo_out_valid; // fifo holds a word
  logic [15:0] fifo_out_data; // head word
  logic rx_take; // incoming frame accepted
  logic pio_push; // accepted packet or data word

  // apb phase decode
  assign setup_ph = psel & ~penable;
  assign access = psel & penable;
  // only words still owed by the setup frame go in
  assign data_wr = access & pwrite & (paddr == A_DATA)
    & (r.st == ST_PIO_OUT) & (r.push_left != '0); // [RULE5] [RULE11]
  // a full fifo stretches the write, backing up software
  assign pready = data_wr ? fifo_in_ready : 1'b1; // [RULE11]
  assign pslverr = access & ~hit;
  assign wr_done = access & pwrite & pready;
  assign rd_done = access & ~pwrite;
  assign pio_push = data_wr & fifo_in_ready;
  assign prdata = r.prdata;
  assign host_irq = r.irq;

  // register read mux and address decode
  always_comb
  begin
    hit = 1'b1;
    rd_mux = '0;
    case (paddr)
      A_DATA: rd_mux = '0; // write only port
      A_FEAT: rd_mux = 32'(r.error);
      A_COUNT: rd_mux = 32'(r.count);
      A_LBA: rd_mux = 32'(r.lba);
      A_DEV: rd_mux = 32'(r.device);
      A_CMD, A_ALTST: rd_mux = 32'(r.status); // [RULE21]
      A_BCNT: rd_mux = 32'({r.xfer_words, 1'b0}); // bytes = 2 x words
      A_DMA_ADDR: rd_mux = r.dma_addr;
      A_DMA_CNT: rd_mux = 32'(r.dma_count);
      A_DMA_CTRL: rd_mux = 32'({r.dma_tomem, r.dma_run});
      A_DMA_STAT: rd_mux = 32'({r.dma_done, r.dma_active,
        r.dma_run & ~r.dma_active});
      default: hit = 1'b0; // unmapped: error, reads zero
    endcase
  end

  // fifo feeding: packet and pio words from software, else dma reads
  assign push = pio_push | (r.mr_pend & mem_rd_ready); // [RULE6]
  assign push_data = data_wr ? pwdata[15:0] : mem_rd_data;

  aps_fifo u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop), // only words owed to the frame leave the head
    .out_data(fifo_out_data)
  );

  // link side: offer only real words, so no underflow mid frame
  assign tx_valid = fifo_out_valid & (r.pop_left != '0); // [RULE7]
  assign pop = tx_valid & tx_ready; // [RULE6]
  assign tx_data = fifo_out_data;
  // last word lets the link append crc and end of frame
  assign tx_last = (r.pop_left == ONE_WORD); // [RULE8]

  // command frame carries the shadow block
  assign tx_cmd_valid = (r.st == ST_CMD_TX); // [RULE2]
  assign tx_cmd_command = r.command;
  assign tx_cmd_features = r.features;
  assign tx_cmd_count = r.count;
  assign tx_cmd_device = r.device;
  assign tx_cmd_lba = r.lba;

  // data frames stall while the memory stage is occupied
  assign rx_ready = (rx_type == FR_DATA) ? ~r.mw_valid : 1'b1;
  assign rx_take = rx_valid & rx_ready;

  // dma memory ports
  assign mem_wr_valid = r.mw_valid;
  assign mem_wr_addr = r.mw_addr;
  assign mem_wr_data = r.mw_data;
  assign mem_rd_valid = r.mr_pend;
  assign mem_rd_addr = r.mem_addr;

  // next state
  always_comb
  begin
    next_r = r;
    // read data sampled at setup, steady through access
    if (setup_ph)
      next_r.prdata = hit ? rd_mux : '0;
    // software writes to the shadow and dma registers
    if (wr_done)
    begin
      case (paddr)
        A_FEAT: next_r.features = pwdata[7:0];
        A_COUNT: next_r.count = pwdata[7:0];
        A_LBA: next_r.lba = pwdata[23:0];
        A_DEV: next_r.device = pwdata[7:0];
        A_CMD:
        begin
          // command is the last setup access, so launch now
          next_r.command = pwdata[7:0]; // [RULE1]
          next_r.status[BUSY_BIT] = 1'b1; // [RULE2] [RULE21]
          next_r.status[XFER_BIT] = 1'b0;
          next_r.st = ST_CMD_TX; // [RULE2]
        end
        A_DMA_ADDR: next_r.dma_addr = pwdata;
        A_DMA_CNT: next_r.dma_count = pwdata[15:0];
        A_DMA_CTRL:
        begin
          // run only arms; nothing moves until activate or data
          next_r.dma_run = pwdata[CTRL_RUN]; // [RULE18]
          next_r.dma_tomem = pwdata[CTRL_TOMEM];
          next_r.dma_active = 1'b0;
          next_r.dma_done = 1'b0;
          next_r.mem_addr = r.dma_addr; // [RULE14]
          next_r.dma_left = r.dma_count;
        end
        default: ; // data and read only offsets
      endcase
    end
    // reading status acknowledges the interrupt
    if (rd_done && paddr == A_CMD)
      next_r.irq = 1'b0;
    // command frame taken by the link
    if (r.st == ST_CMD_TX && tx_cmd_ready)
      next_r.st = ST_WAIT; // [RULE2]
    // word written by software
    if (pio_push)
    begin
      next_r.push_left = r.push_left - ONE_WORD; // [RULE6]
      if (r.push_left == ONE_WORD)
      begin
        // all owed words in: final status, busy back on
        next_r.status = r.end_status; // [RULE8]
        next_r.st = ST_WAIT;
      end
    end
    // word handed to the link
    if (pop)
    begin
      next_r.pop_left = r.pop_left - ONE_WORD;
      if (r.pop_left == ONE_WORD && r.dma_active)
      begin
        next_r.dma_active = 1'b0; // [RULE20]
        next_r.dma_done = 1'b1;
      end
    end
    // outbound dma fetch, one read at a time
    if (r.mr_pend)
    begin
      if (mem_rd_ready)
      begin
        next_r.mr_pend = 1'b0;
        next_r.mem_addr = r.mem_addr + WORD_STEP;
        next_r.dma_left = r.dma_left - ONE_WORD; // [RULE20]
      end
    end
    else if (r.dma_active && !r.dma_tomem && r.dma_left != '0
      && fifo_in_ready && r.st != ST_PIO_OUT)
      next_r.mr_pend = 1'b1; // [RULE18] [RULE20]
    // memory write stage drains
    if (r.mw_valid && mem_wr_ready)
      next_r.mw_valid = 1'b0;
    // incoming frames; interrupt sets after the status read clear
    if (rx_take)
    begin
      case (rx_type)
        FR_PIO_SETUP:
        begin
          // beginning status clears busy, sets request
          next_r.status = rx_status; // [RULE4] [RULE10]
          next_r.end_status = rx_end_status; // [RULE8]
          next_r.xfer_words = rx_words; // [RULE11]
          next_r.push_left = rx_words;
          next_r.pop_left = rx_words; // [RULE3] [RULE9]
          if (!rx_to_host)
            next_r.st = ST_PIO_OUT; // [RULE10]
          if (rx_irq)
            next_r.irq = 1'b1; // [RULE10]
        end
        FR_DMA_ACT:
        begin
          // remainder goes out as one frame
          if (r.dma_run && !r.dma_tomem && r.dma_left != '0)
          begin
            next_r.dma_active = 1'b1; // [RULE19]
            next_r.pop_left = r.dma_left; // [RULE20]
          end
        end
        FR_DATA:
        begin
          // words past the count are dropped
          if (r.dma_run && r.dma_tomem && r.dma_left != '0)
          begin
            next_r.mw_valid = 1'b1; // [RULE16]
            next_r.mw_data = rx_data;
            next_r.mw_addr = r.mem_addr;
            next_r.mem_addr = r.mem_addr + WORD_STEP;
            next_r.dma_left = r.dma_left - ONE_WORD; // [RULE15]
            if (r.dma_left == ONE_WORD)
              next_r.dma_done = 1'b1;
          end
        end
        FR_REG_D2H:
        begin
          // ending status lands in the shadow block
          next_r.status = rx_status; // [RULE13] [RULE17]
          next_r.error = rx_error; // [RULE12]
          next_r.count = rx_count_reg;
          next_r.lba = rx_lba;
          if (!rx_status[BUSY_BIT])
            next_r.st = ST_IDLE; // [RULE13]
          if (rx_irq)
            next_r.irq = 1'b1; // [RULE17]
        end
        default: ;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= REGS_RST;
    else
      r <= next_r;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cmd_wr;
    wr_done && paddr == A_CMD;
  endsequence
  sequence s_frame_out;
    tx_cmd_valid && tx_cmd_ready && !rx_take;
  endsequence
  sequence s_wr_setup;
    rx_take && rx_type == FR_PIO_SETUP && !rx_to_host;
  endsequence

  a_cmd_sets_busy: assert property ( // [RULE2]
    s_cmd_wr |=> r.status[BUSY_BIT] && tx_cmd_valid)
    else $error("command write did not set busy and send frame");
  a_cmd_frame_done: assert property ( // [RULE2]
    s_frame_out |=> !tx_cmd_valid && r.st == ST_WAIT)
    else $error("command frame did not retire after acceptance");
  a_setup_status: assert property ( // [RULE4]
    s_wr_setup |=> r.status == $past(rx_status) && r.st == ST_PIO_OUT)
    else $error("setup frame status not loaded");
  a_setup_irq: assert property ( // [RULE10]
    s_wr_setup ##0 rx_irq |=> host_irq)
    else $error("flagged setup frame raised no interrupt");
  a_tx_hold: assert property ( // [RULE7]
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("link word dropped while throttled");
  a_final_status: assert property ( // [RULE8]
    pio_push && r.push_left == ONE_WORD |=>
      r.status == $past(r.end_status) && r.st == ST_WAIT)
    else $error("final status not loaded at word count");
  a_frame_close: assert property ( // [RULE8]
    pop && tx_last && !rx_take |=> r.pop_left == '0 && !tx_valid)
    else $error("frame kept sending after last word");
  a_reg_done: assert property ( // [RULE13]
    rx_take && rx_type == FR_REG_D2H |=>
      r.status == $past(rx_status) && (host_irq || !$past(rx_irq)))
    else $error("register frame not copied to shadow");
  a_dma_route: assert property ( // [RULE16]
    rx_take && rx_type == FR_DATA && r.dma_run && r.dma_tomem
      && r.dma_left != '0 |=> mem_wr_valid && mem_wr_data == $past(rx_data))
    else $error("data frame not routed to memory");
  a_dma_paused: assert property ( // [RULE18]
    !r.dma_active && !r.mr_pend |=> !mem_rd_valid)
    else $error("dma fetched before activation");
  a_dma_count: assert property ( // [RULE20]
    mem_rd_valid |-> r.dma_left != '0)
    else $error("dma read beyond programmed count");
endmodule
`default_nettype wire

// ===== core/aps_pkg.sv
package aps_pkg;
  // apb byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_DATA = 8'h00;
  localparam logic [7:0] A_FEAT = 8'h04;
  localparam logic [7:0] A_COUNT = 8'h08;
  localparam logic [7:0] A_LBA = 8'h0C;
  localparam logic [7:0] A_DEV = 8'h10;
  localparam logic [7:0] A_CMD = 8'h14;
  localparam logic [7:0] A_ALTST = 8'h18;
  localparam logic [7:0] A_BCNT = 8'h1C;
  localparam logic [7:0] A_DMA_ADDR = 8'h20;
  localparam logic [7:0] A_DMA_CNT = 8'h24;
  localparam logic [7:0] A_DMA_CTRL = 8'h28;
  localparam logic [7:0] A_DMA_STAT = 8'h2C;
  // shadow status bit positions
  localparam int BUSY_BIT = 7;
  localparam int XFER_BIT = 3;
  // dma control and status bits
  localparam int CTRL_RUN = 0;
  localparam int CTRL_TOMEM = 1;
  localparam int DST_ARMED = 0;
  localparam int DST_ACTIVE = 1;
  localparam int DST_DONE = 2;
  // word counting
  localparam logic [15:0] ONE_WORD = 16'h0001;
  localparam logic [31:0] WORD_STEP = 32'h0000_0002;
  // outbound fifo shape
  localparam int FIFO_W = 16;
  localparam int FIFO_D = 8;
  localparam int FIFO_AW = 3;
  localparam logic [FIFO_AW:0] FIFO_FULL = 4'h8;
  // incoming frame kinds
  typedef enum logic [1:0] {FR_REG_D2H, FR_PIO_SETUP, FR_DMA_ACT, FR_DATA}
    aps_frame_t;
  // sequencer phases
  typedef enum logic [1:0] {ST_IDLE, ST_CMD_TX, ST_WAIT, ST_PIO_OUT}
    aps_state_t;
  // whole sequencer state
  typedef struct packed {
    aps_state_t st;
    logic [7:0] features;
    logic [7:0] count;
    logic [7:0] device;
    logic [7:0] command;
    logic [7:0] status;
    logic [7:0] error;
    logic [23:0] lba;
    logic [7:0] end_status;
    logic [15:0] xfer_words;
    logic [15:0] push_left;
    logic [15:0] pop_left;
    logic irq;
    logic [31:0] dma_addr;
    logic [15:0] dma_count;
    logic dma_run;
    logic dma_tomem;
    logic dma_active;
    logic dma_done;
    logic [31:0] mem_addr;
    logic [15:0] dma_left;
    logic mw_valid;
    logic [15:0] mw_data;
    logic [31:0] mw_addr;
    logic mr_pend;
    logic [31:0] prdata;
  } aps_regs_t;
  localparam aps_regs_t REGS_RST = '0;
  // fifo state
  typedef struct packed {
    logic [FIFO_D-1:0][FIFO_W-1:0] mem;
    logic [FIFO_AW-1:0] wp;
    logic [FIFO_AW-1:0] rp;
    logic [FIFO_AW:0] cnt;
  } aps_fifo_t;
  localparam aps_fifo_t FIFO_RST = '0;
endpackage

// ===== core/aps_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module aps_fifo
  import aps_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [FIFO_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [FIFO_W-1:0] out_data
);
  aps_fifo_t f;
  aps_fifo_t next_f;
  logic wr;
  logic rd;

  // honest flags straight from the fill count
  assign in_ready = (f.cnt != FIFO_FULL);
  assign out_valid = (f.cnt != '0);
  assign out_data = f.mem[f.rp];
  assign wr = in_valid & in_ready;
  assign rd = out_valid & out_ready;

  // pointer and count update
  always_comb
  begin
    next_f = f;
    if (wr)
    begin
      next_f.mem[f.wp] = in_data;
      next_f.wp = f.wp + 1'b1;
    end
    if (rd)
      next_f.rp = f.rp + 1'b1;
    // simultaneous push and pop keep the count
    if (wr && !rd)
      next_f.cnt = f.cnt + 1'b1;
    else if (rd && !wr)
      next_f.cnt = f.cnt - 1'b1;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      f <= FIFO_RST;
    else
      f <= next_f;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_fifo_count: assert property (wr && !rd |=> f.cnt == $past(f.cnt) + 1'b1)
    else $error("fifo count did not grow on push");
endmodule
`default_nettype wire

// ===== sim/aps_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module aps_dev_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic tx_cmd_valid,
  output logic tx_cmd_ready,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [15:0] tx_data,
  input wire logic tx_last,
  input wire logic mem_wr_valid,
  output logic mem_wr_ready,
  input wire logic [31:0] mem_wr_addr,
  input wire logic [15:0] mem_wr_data,
  input wire logic mem_rd_valid,
  output logic mem_rd_ready,
  input wire logic [31:0] mem_rd_addr,
  output logic [15:0] mem_rd_data
);
  logic [3:0] ph; // free phase count, drives the stalls
  logic [15:0] words[$]; // words taken off the link
  logic [31:0] wr_log[$]; // memory writes, {addr low, data}
  int ncmd; // command frames taken
  int last_n; // word total when a frame closed
  // slow mode drops ready every other cycle, so no ready is ever assumed
  assign tx_ready = !slow | ph[0];
  assign tx_cmd_ready = ph[1];
  assign mem_wr_ready = ph[0];
  assign mem_rd_ready = ph[0];
  // read data only means something while ready; else a moving pattern
  assign mem_rd_data = ph[0] ? (mem_rd_addr[15:0] ^ 16'h5A5A) : {4{ph}};
  // record accepted command frames, link words and memory writes for the bench to judge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph <= 4'h0;
      ncmd <= 0;
    end
    else
    begin
      ph <= ph + 4'h1;
      if (tx_cmd_valid && tx_cmd_ready)
        ncmd <= ncmd + 1;
      if (tx_valid && tx_ready)
        words.push_back(tx_data);
      if (tx_valid && tx_ready && tx_last)
        last_n <= words.size();
      if (mem_wr_valid && mem_wr_ready)
        wr_log.push_back({mem_wr_addr[15:0], mem_wr_data});
    end
  end
endmodule
`default_nettype wire

// ===== sim/atapi_packet_host_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module atapi_packet_host_sequencer_tb_top
  import aps_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, slow, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, host_irq;
  logic tx_cmd_valid, tx_cmd_ready, tx_valid, tx_ready, tx_last;
  logic [7:0] tx_cmd_command, tx_cmd_features, tx_cmd_count, tx_cmd_device;
  logic [23:0] tx_cmd_lba, rx_lba;
  logic [15:0] tx_data, rx_words, rx_data, mem_wr_data, mem_rd_data;
  logic rx_valid, rx_ready, rx_to_host, rx_irq;
  aps_frame_t rx_type;
  logic [7:0] rx_status, rx_end_status, rx_error, rx_count_reg;
  logic mem_wr_valid, mem_wr_ready, mem_rd_valid, mem_rd_ready;
  logic [31:0] mem_wr_addr, mem_rd_addr;
  int failures, cmp_count;
  // block under test, every pin by name
  aps_sequencer u_aps_sequencer (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .host_irq, .tx_cmd_valid,
    .tx_cmd_ready, .tx_cmd_command, .tx_cmd_features, .tx_cmd_count,
    .tx_cmd_device, .tx_cmd_lba, .tx_valid, .tx_ready, .tx_data, .tx_last,
    .rx_valid, .rx_ready, .rx_type, .rx_status, .rx_end_status, .rx_error,
    .rx_count_reg, .rx_lba, .rx_words, .rx_to_host, .rx_irq, .rx_data,
    .mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data, .mem_rd_valid,
    .mem_rd_ready, .mem_rd_addr, .mem_rd_data);
  // far device and host memory
  aps_dev_model u_aps_dev_model (.pclk, .presetn, .slow, .tx_cmd_valid,
    .tx_cmd_ready, .tx_valid, .tx_ready, .tx_data, .tx_last, .mem_wr_valid,
    .mem_wr_ready, .mem_wr_addr, .mem_wr_data, .mem_rd_valid, .mem_rd_ready,
    .mem_rd_addr, .mem_rd_data);
  // 20 MHz
  always #25 pclk = ~pclk;
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // a wait that ran out is a mismatch
  task automatic hang();
    failures++;
    end_of_test();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic ckb(input logic [7:0] g, input logic [7:0] e);
    chk({24'h0, g}, {24'h0, e});
  endtask
  // one apb transfer; pready, data and error taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 200)
        hang();
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the completing edge settle before outputs are judged
    @(negedge pclk);
  endtask
  // one incoming frame from the device, held until taken
  task automatic frame(input aps_frame_t t, input logic [7:0] s, es,
    input logic [15:0] w, input logic ir);
    int n;
    n = 0;
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_type <= t;
    rx_status <= s;
    rx_end_status <= es;
    rx_error <= es;
    rx_count_reg <= w[7:0];
    rx_lba <= {8'h00, w};
    rx_words <= w;
    rx_data <= w;
    rx_irq <= ir;
    @(negedge pclk);
    while (rx_ready !== 1'b1)
    begin
      n++;
      if (n > 200)
        hang();
      @(negedge pclk);
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~w;
    @(negedge pclk);
  endtask
  function automatic int got(input int s);
    if (s == 0)
      return u_aps_dev_model.words.size();
    if (s == 1)
      return u_aps_dev_model.wr_log.size();
    return u_aps_dev_model.ncmd;
  endfunction
  task automatic wait_n(input int s, input int k);
    int n;
    n = 0;
    while (got(s) < k)
    begin
      n++;
      if (n > 500)
        hang();
      @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
  endtask
  // status after reset, unmapped access refused
  task automatic t_reset();
    apb(1'b0, A_CMD, 32'h0);
    ckb(rd[7:0], 8'h00);
    apb(1'b0, 8'h3C, 32'h0);
    ckb({7'h0, err}, 8'h01);
  endtask
  // packet phase then pio write data, ending register frame
  task automatic t_pio();
    apb(1'b1, A_LBA, 32'h0012_3456);
    apb(1'b1, A_FEAT, 32'h0000_0003);
    apb(1'b1, A_COUNT, 32'h0000_000C);
    apb(1'b1, A_DEV, 32'h0000_00E0);
    apb(1'b1, A_CMD, 32'h0000_00A0);
    apb(1'b0, A_ALTST, 32'h0);
    ckb(rd[7:0], 8'h80);
    wait_n(2, 1);
    ckb(tx_cmd_command, 8'hA0);
    chk({8'h0, tx_cmd_lba}, 32'h0012_3456);
    ckb(tx_cmd_features, 8'h03);
    ckb(tx_cmd_count, 8'h0C);
    ckb(tx_cmd_device, 8'hE0);
    frame(FR_PIO_SETUP, 8'h58, 8'h80, 16'h0002, 1'b0);
    apb(1'b0, A_ALTST, 32'h0);
    ckb(rd[7:0], 8'h58);
    slow <= 1'b1;
    apb(1'b1, A_DATA, 32'h0000_1111);
    apb(1'b1, A_DATA, 32'h0000_2222);
    apb(1'b1, A_DATA, 32'h0000_3333);
    wait_n(0, 2);
    chk({16'h0, u_aps_dev_model.words[1]}, 32'h2222);
    chk(32'(u_aps_dev_model.last_n), 32'd2);
    apb(1'b0, A_ALTST, 32'h0);
    ckb(rd[7:0], 8'h80);
    slow <= 1'b0;
    frame(FR_PIO_SETUP, 8'h48, 8'hD0, 16'h0003, 1'b1);
    ckb({7'h0, host_irq}, 8'h01);
    apb(1'b0, A_BCNT, 32'h0);
    ckb(rd[7:0], 8'h06);
    for (int i = 0; i < 3; i++)
      apb(1'b1, A_DATA, 32'h0000_4440 + i);
    wait_n(0, 5);
    chk({16'h0, u_aps_dev_model.words[2]}, 32'h4440);
    chk(32'(u_aps_dev_model.last_n), 32'd5);
    apb(1'b0, A_ALTST, 32'h0);
    ckb(rd[7:0], 8'hD0);
    frame(FR_REG_D2H, 8'h50, 8'h21, 16'h0033, 1'b1);
    apb(1'b0, A_CMD, 32'h0);
    ckb(rd[7:0], 8'h50);
    ckb({7'h0, host_irq}, 8'h00);
    apb(1'b0, A_FEAT, 32'h0);
    ckb(rd[7:0], 8'h21);
    apb(1'b0, A_COUNT, 32'h0);
    ckb(rd[7:0], 8'h33);
  endtask
  // incoming data steered to memory, quiet ending frame
  task automatic t_dma_in();
    apb(1'b1, A_DMA_ADDR, 32'h0000_1000);
    apb(1'b1, A_DMA_CNT, 32'h0000_0002);
    apb(1'b1, A_DMA_CTRL, 32'h0000_0003);
    frame(FR_DATA, 8'h00, 8'h00, 16'hBEEF, 1'b0);
    frame(FR_DATA, 8'h00, 8'h00, 16'hCAFE, 1'b0);
    wait_n(1, 2);
    chk(u_aps_dev_model.wr_log[0], 32'h1000_BEEF);
    chk(u_aps_dev_model.wr_log[1], 32'h1002_CAFE);
    frame(FR_REG_D2H, 8'h50, 8'h00, 16'h0000, 1'b0);
    ckb({7'h0, host_irq}, 8'h00);
  endtask
  // armed engine waits for activate, then sends the programmed count
  task automatic t_dma_out();
    slow <= 1'b1;
    apb(1'b1, A_DMA_ADDR, 32'h0000_2000);
    apb(1'b1, A_DMA_CNT, 32'h0000_0003);
    apb(1'b1, A_DMA_CTRL, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    chk(32'(got(0)), 32'd5);
    apb(1'b0, A_DMA_STAT, 32'h0);
    ckb(rd[7:0] & 8'h03, 8'h01);
    frame(FR_DMA_ACT, 8'h00, 8'h00, 16'h0000, 1'b0);
    wait_n(0, 8);
    for (int i = 0; i < 3; i++)
      chk({16'h0, u_aps_dev_model.words[5 + i]},
        {16'h0, (16'h2000 + 16'(2 * i)) ^ 16'h5A5A});
    chk(32'(u_aps_dev_model.last_n), 32'd8);
    repeat (10) @(posedge pclk);
    chk(32'(got(0)), 32'd8);
    apb(1'b0, A_DMA_STAT, 32'h0);
    ckb(rd[7:0], 8'h05);
  endtask
  // main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, slow, rx_valid} = '0;
    {rx_to_host, rx_irq, failures, cmp_count} = '0;
    {paddr, pwdata, rx_status, rx_end_status, rx_error} = '0;
    {rx_count_reg, rx_lba, rx_words, rx_data} = '0;
    rx_type = FR_REG_D2H;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pio();
    t_dma_in();
    t_dma_out();
    end_of_test();
  end
  // overall cap on run time
  initial
  begin
    #2000000;
    hang();
  end
endmodule
`default_nettype wire
